// ### hw/acs_pkg.sv
// constants shared by the converter interface block
package acs_pkg;
  // register byte addresses on the memory-mapped bus
  localparam logic [31:0] ACS_ADDR_POS   = 32'hFFFF0504;
  localparam logic [31:0] ACS_ADDR_NEG   = 32'hFFFF0508;
  localparam logic [31:0] ACS_ADDR_STA   = 32'hFFFF050C;
  localparam logic [31:0] ACS_ADDR_DAT   = 32'hFFFF0510;
  localparam logic [31:0] ACS_ADDR_RST   = 32'hFFFF0514;
  localparam logic [31:0] ACS_ADDR_GAIN  = 32'hFFFF0530;
  localparam logic [31:0] ACS_ADDR_OFS   = 32'hFFFF0534;
  // values after reset
  localparam logic [7:0]  ACS_POS_RST    = 8'h00;
  localparam logic [7:0]  ACS_NEG_RST    = 8'h01;
  localparam logic [7:0]  ACS_IRST_RST   = 8'h00;
  localparam logic [31:0] ACS_DAT_RST    = 32'h00000000;
  // field positions
  localparam int          ACS_READY_BIT  = 0;
  localparam int          ACS_BUSYEN_BIT = 6;
  localparam int          ACS_START_BIT  = 7;
  localparam int          ACS_MODE_LSB   = 3;
  localparam int          ACS_SEL_W      = 5;
  localparam int          ACS_RES_W      = 12;
  localparam int          ACS_CAL_W      = 10;
  // index of the first trial bit; conversion takes one clock more than this
  localparam logic [3:0]  ACS_LAST_BIT   = 4'hB;
  // input modes
  localparam logic [1:0]  ACS_MODE_SE    = 2'h0;
  localparam logic [1:0]  ACS_MODE_DIFF  = 2'h1;
  localparam logic [1:0]  ACS_MODE_PSD   = 2'h2;
  // selector output codes
  localparam logic [4:0]  ACS_SRC_NONE   = 5'h1F;
  localparam logic [4:0]  ACS_SRC_AGND   = 5'h11;
  // sequencer states, one-hot
  typedef enum logic [2:0]
  {
    ACS_IDLE = 3'h1,
    ACS_ACQ  = 3'h2,
    ACS_CONV = 3'h4
  } acs_state_t;
endpackage

// ### hw/acs_sar.sv
// successive-approximation sequencer, one result bit per clock
module acs_sar
  import acs_pkg::*;
#(
  parameter int RES_W = 12
)
(
  input  wire logic             clk,
  input  wire logic             reset_n,
  input  wire logic             clear,
  input  wire logic             start,
  input  wire logic             cmp_high,
  output logic                  sampling,
  output logic                  busy,
  output logic                  done,
  output logic [RES_W-1:0]      trial,
  output logic [RES_W-1:0]      code
);
  typedef struct packed
  {
    acs_state_t       st;
    logic [3:0]       idx;
    logic [RES_W-1:0] sar;
    logic [RES_W-1:0] res;
    logic             done;
  } acs_sar_st_t;

  acs_sar_st_t s_r;
  acs_sar_st_t s_nxt;

  // start ends acquisition; then msb-first trial bits down to bit 0
  always_comb
  begin
    s_nxt      = s_r;
    s_nxt.done = 1'b0;
    case (s_r.st)
      ACS_IDLE:
      begin
        if (start)
        begin
          s_nxt.st  = ACS_CONV;
          s_nxt.idx = ACS_LAST_BIT;
          s_nxt.sar = {1'b1, {(RES_W-1){1'b0}}};
        end
      end
      ACS_CONV:
      begin
        // keep the trial bit only when the comparator says input is above
        if (!cmp_high)
          s_nxt.sar[s_r.idx] = 1'b0;
        if (s_r.idx == 4'h0)
        begin
          s_nxt.st   = ACS_IDLE;
          s_nxt.res  = s_nxt.sar;
          s_nxt.done = 1'b1;
        end
        else
        begin
          s_nxt.idx = s_r.idx - 4'h1;
          s_nxt.sar[s_r.idx - 4'h1] = 1'b1;
        end
      end
      default:
        s_nxt.st = ACS_IDLE;
    endcase
    if (clear)
    begin
      s_nxt.st   = ACS_IDLE;
      s_nxt.done = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      s_r.st   <= ACS_IDLE;
      s_r.idx  <= 4'h0;
      s_r.sar  <= '0;
      s_r.res  <= '0;
      s_r.done <= 1'b0;
    end
    else
      s_r <= s_nxt;
  end

  assign sampling = (s_r.st != ACS_CONV);
  assign busy     = (s_r.st == ACS_CONV);
  assign done     = s_r.done;
  assign trial    = s_r.sar;
  assign code     = s_r.res;

  // run length read back from done: busy twelve edges ago, idle before
  property p_sar_len;
    @(posedge clk) disable iff (!reset_n)
    done |-> $past(busy, 12) && !$past(busy, 13);
  endproperty
  a_sar_len: assert property (p_sar_len)
    else $error("conversion did not take twelve clocks");

  property p_busy_drop;
    @(posedge clk) disable iff (!reset_n)
    done |-> !busy && $past(busy);
  endproperty
  a_busy_drop: assert property (p_busy_drop)
    else $error("busy not dropped at completion");
endmodule

// ### hw/acs_top.sv
// converter register interface, input routing and busy pin
module acs_top
  import acs_pkg::*;
#(
  parameter logic [9:0] GAIN_FACTORY = 10'h200,
  parameter logic [9:0] OFS_FACTORY  = 10'h200
)
(
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic [31:0] bus_addr,
  input  wire logic        bus_wr,
  input  wire logic        bus_rd,
  input  wire logic [31:0] bus_wdata,
  output logic [31:0]      bus_rdata,
  input  wire logic [15:0] converter_control,
  input  wire logic        conv_trigger,
  input  wire logic        comparator_high,
  input  wire logic        port0_line0_gpio,
  output logic             port0_line0,
  output logic             converter_busy_output,
  output logic             conversion_irq,
  output logic [4:0]       pos_route,
  output logic [4:0]       neg_route,
  output logic             sample_switch_closed,
  output logic [11:0]      dac_trial
);
  typedef struct packed
  {
    logic [7:0]  pos;
    logic [7:0]  neg;
    logic [7:0]  irst;
    logic [9:0]  gain;
    logic [9:0]  ofs;
    logic        ready;
    logic [31:0] dat;
    logic [31:0] rdata;
  } acs_top_st_t;

  acs_top_st_t s_r;
  acs_top_st_t s_nxt;

  logic        sar_busy;
  logic        sar_done;
  logic        sar_samp;
  logic [11:0] sar_code;
  logic        start_req;
  logic [1:0]  mode;
  logic        soft_clear;

  // classify positive selector: 1 when the code names a real source
  function automatic logic pos_valid(input logic [4:0] c);
    pos_valid = (c <= 5'h0A) || (c == 5'h0C) || (c == 5'h0E) ||
                (c == 5'h0F) || ((c >= 5'h10) && (c <= 5'h13));
  endfunction

  function automatic logic neg_valid(input logic [4:0] c);
    neg_valid = (c <= 5'h0A) || (c == 5'h0C) ||
                ((c >= 5'h0F) && (c <= 5'h12));
  endfunction

  // saturating add of signed offset correction to the raw code
  function automatic logic [11:0] correct(input logic [11:0] raw,
                                          input logic [9:0]  ofs);
    logic signed [13:0] sum;
    sum = $signed({2'b00, raw}) + $signed({{4{ofs[9]}}, ofs});
    if (sum < 0)
      correct = 12'h000;
    else if (sum > 14'sh0FFF)
      correct = 12'hFFF;
    else
      correct = sum[11:0];
  endfunction

  assign mode       = converter_control[ACS_MODE_LSB +: 2];
  assign start_req  = conv_trigger && converter_control[ACS_START_BIT];
  assign soft_clear = bus_wr && (bus_addr == ACS_ADDR_RST);

  acs_sar #(.RES_W(ACS_RES_W)) u_sar
  (
    .clk      (clk),
    .reset_n  (reset_n),
    .clear    (soft_clear),
    .start    (start_req),
    .cmp_high (comparator_high),
    .sampling (sar_samp),
    .busy     (sar_busy),
    .done     (sar_done),
    .trial    (dac_trial),
    .code     (sar_code)
  );

  // register writes, flag update and read data
  always_comb
  begin
    s_nxt = s_r;
    if (bus_wr)
    begin
      case (bus_addr)
        ACS_ADDR_POS:  s_nxt.pos  = bus_wdata[7:0];
        ACS_ADDR_NEG:  s_nxt.neg  = bus_wdata[7:0];
        ACS_ADDR_GAIN: s_nxt.gain = bus_wdata[9:0];
        ACS_ADDR_OFS:  s_nxt.ofs  = bus_wdata[9:0];
        default:       s_nxt.irst = s_r.irst;
      endcase
    end
    // reading the result acknowledges; a finishing conversion wins
    if (bus_rd && (bus_addr == ACS_ADDR_DAT))
      s_nxt.ready = 1'b0;
    if (sar_done)
    begin
      s_nxt.ready = 1'b1;
      s_nxt.dat   = {20'h00000, correct(sar_code, s_r.ofs)};
    end
    // interface reset: written data deliberately unused
    if (soft_clear)
    begin
      s_nxt.pos   = ACS_POS_RST;
      s_nxt.neg   = ACS_NEG_RST;
      s_nxt.irst  = ACS_IRST_RST;
      s_nxt.gain  = GAIN_FACTORY;
      s_nxt.ofs   = OFS_FACTORY;
      s_nxt.ready = 1'b0;
      s_nxt.dat   = ACS_DAT_RST;
    end
    // read data registered, so it appears one cycle after the strobe
    case (bus_addr)
      ACS_ADDR_POS:  s_nxt.rdata = {24'h000000, s_r.pos};
      ACS_ADDR_NEG:  s_nxt.rdata = {24'h000000, s_r.neg};
      ACS_ADDR_STA:  s_nxt.rdata = {31'h00000000, s_r.ready};
      ACS_ADDR_DAT:  s_nxt.rdata = s_r.dat;
      ACS_ADDR_RST:  s_nxt.rdata = {24'h000000, s_r.irst};
      ACS_ADDR_GAIN: s_nxt.rdata = {22'h000000, s_r.gain};
      ACS_ADDR_OFS:  s_nxt.rdata = {22'h000000, s_r.ofs};
      default:       s_nxt.rdata = 32'h00000000;
    endcase
    if (!bus_rd)
      s_nxt.rdata = 32'h00000000;
  end

  // factory calibration taken as constants at reset
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      s_r.pos   <= ACS_POS_RST;
      s_r.neg   <= ACS_NEG_RST;
      s_r.irst  <= ACS_IRST_RST;
      s_r.gain  <= GAIN_FACTORY;
      s_r.ofs   <= OFS_FACTORY;
      s_r.ready <= 1'b0;
      s_r.dat   <= ACS_DAT_RST;
      s_r.rdata <= 32'h00000000;
    end
    else
      s_r <= s_nxt;
  end

  // input routing; disconnected while converting, reserved codes open
  always_comb
  begin
    pos_route = ACS_SRC_NONE;
    neg_route = ACS_SRC_NONE;
    if (sar_samp)
    begin
      if (pos_valid(s_r.pos[4:0]))
        pos_route = s_r.pos[4:0];
      case (mode)
        ACS_MODE_SE:   neg_route = ACS_SRC_AGND;
        ACS_MODE_DIFF,
        ACS_MODE_PSD:
        begin
          if (neg_valid(s_r.neg[4:0]))
            neg_route = s_r.neg[4:0];
        end
        default:       neg_route = ACS_SRC_NONE;
      endcase
    end
  end

  assign sample_switch_closed  = sar_samp;
  assign converter_busy_output = sar_busy;
  // pin is shared: normal function unless busy enable set
  assign port0_line0 = converter_control[ACS_BUSYEN_BIT] ?
                       sar_busy : port0_line0_gpio;
  assign conversion_irq = s_r.ready;
  assign bus_rdata      = s_r.rdata;

  property p_ready_set;
    @(posedge clk) disable iff (!reset_n)
    (sar_done && !soft_clear) |=> s_r.ready && s_r.dat[31:12] == 20'h0;
  endproperty
  a_ready_set: assert property (p_ready_set)
    else $error("ready not set after conversion");

  property p_rd_clear;
    @(posedge clk) disable iff (!reset_n)
    (bus_rd && bus_addr == ACS_ADDR_DAT && !sar_done) |=> !s_r.ready;
  endproperty
  a_rd_clear: assert property (p_rd_clear)
    else $error("result read did not clear ready");

  property p_soft_rst;
    @(posedge clk) disable iff (!reset_n)
    soft_clear |=> s_r.pos == ACS_POS_RST && s_r.neg == ACS_NEG_RST
                   && !s_r.ready && s_r.dat == ACS_DAT_RST;
  endproperty
  a_soft_rst: assert property (p_soft_rst)
    else $error("interface reset did not restore defaults");

  property p_pin;
    @(posedge clk) disable iff (!reset_n)
    converter_control[ACS_BUSYEN_BIT] |-> port0_line0 == converter_busy_output;
  endproperty
  a_pin: assert property (p_pin)
    else $error("busy not on port pin when enabled");

  property p_iso;
    @(posedge clk) disable iff (!reset_n)
    converter_busy_output |-> pos_route == ACS_SRC_NONE
                              && neg_route == ACS_SRC_NONE;
  endproperty
  a_iso: assert property (p_iso)
    else $error("inputs connected during conversion");

  property p_se;
    @(posedge clk) disable iff (!reset_n)
    (sar_samp && mode == ACS_MODE_SE) |-> neg_route == ACS_SRC_AGND;
  endproperty
  a_se: assert property (p_se)
    else $error("single-ended negative not grounded");

  property p_pos_rsv;
    @(posedge clk) disable iff (!reset_n)
    (s_r.pos[4:0] == 5'h0B || s_r.pos[4:0] == 5'h0D ||
     s_r.pos[4:0] > 5'h13)
      |-> pos_route == ACS_SRC_NONE;
  endproperty
  a_pos_rsv: assert property (p_pos_rsv)
    else $error("reserved positive code routed");

  property p_neg_rsv;
    @(posedge clk) disable iff (!reset_n)
    // single-ended mode grounds the negative side whatever the code
    (mode != ACS_MODE_SE) &&
    (s_r.neg[4:0] == 5'h0B || s_r.neg[4:0] == 5'h0D ||
     s_r.neg[4:0] == 5'h0E || s_r.neg[4:0] >= 5'h13)
      |-> neg_route == ACS_SRC_NONE;
  endproperty
  a_neg_rsv: assert property (p_neg_rsv)
    else $error("reserved negative code routed");

  property p_soft_cal;
    @(posedge clk) disable iff (!reset_n)
    soft_clear |=> s_r.gain == GAIN_FACTORY && s_r.ofs == OFS_FACTORY
                   && s_r.irst == ACS_IRST_RST;
  endproperty
  a_soft_cal: assert property (p_soft_cal)
    else $error("interface reset left calibration changed");

  property p_gain_wr;
    @(posedge clk) disable iff (!reset_n)
    (bus_wr && bus_addr == ACS_ADDR_GAIN)
      |=> {22'h000000, s_r.gain} == ($past(bus_wdata) & 32'h000003FF);
  endproperty
  a_gain_wr: assert property (p_gain_wr)
    else $error("gain write not stored");

  property p_ofs_wr;
    @(posedge clk) disable iff (!reset_n)
    (bus_wr && bus_addr == ACS_ADDR_OFS)
      |=> {22'h000000, s_r.ofs} == ($past(bus_wdata) & 32'h000003FF);
  endproperty
  a_ofs_wr: assert property (p_ofs_wr)
    else $error("offset write not stored");

  // status is read-only; only conversions, result reads and the interface reset move it
  property p_sta_ro;
    @(posedge clk) disable iff (!reset_n)
    (bus_wr && bus_addr == ACS_ADDR_STA && !sar_done)
      |=> $stable(s_r.ready);
  endproperty
  a_sta_ro: assert property (p_sta_ro)
    else $error("status changed by a write");

  property p_dat_ro;
    @(posedge clk) disable iff (!reset_n)
    (bus_wr && bus_addr == ACS_ADDR_DAT && !sar_done)
      |=> $stable(s_r.dat);
  endproperty
  a_dat_ro: assert property (p_dat_ro)
    else $error("result changed by a write");

  property p_sta_rd;
    @(posedge clk) disable iff (!reset_n)
    (bus_rd && bus_addr == ACS_ADDR_STA)
      |=> bus_rdata == {31'h00000000, $past(s_r.ready)};
  endproperty
  a_sta_rd: assert property (p_sta_rd)
    else $error("status read returned wrong word");

  property p_dat_rd;
    @(posedge clk) disable iff (!reset_n)
    (bus_rd && bus_addr == ACS_ADDR_DAT) |=> bus_rdata == $past(s_r.dat);
  endproperty
  a_dat_rd: assert property (p_dat_rd)
    else $error("result read returned wrong word");

  property p_irq_rise;
    @(posedge clk) disable iff (!reset_n)
    $rose(conversion_irq) |-> $past(sar_done);
  endproperty
  a_irq_rise: assert property (p_irq_rise)
    else $error("interrupt raised without a finished conversion");

  // a start is taken only when enabled, idle and not being reset
  property p_go;
    @(posedge clk) disable iff (!reset_n)
    (conv_trigger && converter_control[ACS_START_BIT]
     && !converter_busy_output && !soft_clear) |=> converter_busy_output;
  endproperty
  a_go: assert property (p_go)
    else $error("enabled start not taken");

  property p_no_go;
    @(posedge clk) disable iff (!reset_n)
    (!converter_control[ACS_START_BIT] && !converter_busy_output)
      |=> !converter_busy_output;
  endproperty
  a_no_go: assert property (p_no_go)
    else $error("conversion began without start enable");

  property p_mode3;
    @(posedge clk) disable iff (!reset_n)
    (sar_samp && mode == 2'h3) |-> neg_route == ACS_SRC_NONE;
  endproperty
  a_mode3: assert property (p_mode3)
    else $error("reserved mode connected the negative input");
endmodule

// ### bench/acs_cmp_model.sv
// comparator stand-in for the analog front end of the converter
module acs_cmp_model
(
  input  wire logic [11:0] trial,
  input  wire logic [11:0] level,
  output logic             cmp_high
);
  timeunit 1ns;
  timeprecision 1ps;

  // held sample at or above the trial word keeps that bit set
  assign cmp_high = (level >= trial);
endmodule

// ### bench/acs_top_tb.sv
// self-checking bench for the converter register interface
module acs_top_tb;
  import acs_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  localparam logic [9:0] GAIN_F = 10'h155;
  localparam logic [9:0] OFS_F  = 10'h000;

  logic        clk;
  logic        reset_n;
  logic        bus_wr;
  logic        bus_rd;
  logic        trig;
  logic        gpio;
  logic        cmp;
  logic        p0;
  logic        busy;
  logic        irq;
  logic        ssc;
  logic [31:0] addr;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic [15:0] ctl;
  logic [11:0] level;
  logic [11:0] trial;
  logic [4:0]  pr;
  logic [4:0]  nr;
  int          failures;
  int          cmp_count;

  acs_top #(.GAIN_FACTORY(GAIN_F), .OFS_FACTORY(OFS_F)) dut_u
  (
    .clk(clk), .reset_n(reset_n), .bus_addr(addr), .bus_wr(bus_wr),
    .bus_rd(bus_rd), .bus_wdata(wdata), .bus_rdata(rdata),
    .converter_control(ctl), .conv_trigger(trig),
    .comparator_high(cmp), .port0_line0_gpio(gpio), .port0_line0(p0),
    .converter_busy_output(busy), .conversion_irq(irq),
    .pos_route(pr), .neg_route(nr), .sample_switch_closed(ssc),
    .dac_trial(trial)
  );

  acs_cmp_model cmp_u (.trial(trial), .level(level), .cmp_high(cmp));

  // free-running system clock
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      failures++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // one write strobe, held across exactly one sampling edge
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    @(posedge clk);
    #1;
    addr = a;
    wdata = d;
    bus_wr = 1'b1;
    @(posedge clk);
    #1;
    bus_wr = 1'b0;
  endtask

  // read data is registered at the strobe edge and sampled just after
  task automatic rc(input logic [31:0] a, input logic [31:0] exp);
    @(posedge clk);
    #1;
    addr = a;
    bus_rd = 1'b1;
    @(posedge clk);
    #1;
    bus_rd = 1'b0;
    chk(rdata, exp);
  endtask

  task automatic t_reset;
    rc(ACS_ADDR_POS, 32'h00000000);
    rc(ACS_ADDR_NEG, 32'h00000001);
    rc(ACS_ADDR_STA, 32'h00000000);
    rc(ACS_ADDR_DAT, 32'h00000000);
    rc(ACS_ADDR_RST, 32'h00000000);
    rc(ACS_ADDR_GAIN, {22'h000000, GAIN_F});
    rc(ACS_ADDR_OFS, {22'h000000, OFS_F});
    rc(32'hFFFF0520, 32'h00000000);
    $display("test reset_values done");
  endtask

  // calibration is ten bits wide, status and result refuse writes
  task automatic t_regs;
    wr(ACS_ADDR_GAIN, 32'hFFFFFEAA);
    rc(ACS_ADDR_GAIN, 32'h000002AA);
    wr(ACS_ADDR_OFS, 32'h00000005);
    rc(ACS_ADDR_OFS, 32'h00000005);
    wr(ACS_ADDR_STA, 32'h000000FF);
    rc(ACS_ADDR_STA, 32'h00000000);
    wr(ACS_ADDR_DAT, 32'h00000FFF);
    rc(ACS_ADDR_DAT, 32'h00000000);
    $display("test register_access done");
  endtask

  // every selector code; negative route in each input mode, positive route in differential mode only
  task automatic t_route;
    logic [4:0] pe;
    logic [4:0] ne;
    for (int c = 0; c < 32; c++)
    begin
      wr(ACS_ADDR_POS, 32'(c));
      wr(ACS_ADDR_NEG, 32'(c));
      rc(ACS_ADDR_POS, 32'(c));
      pe = (c <= 10 || c == 12 || (c >= 14 && c <= 19)) ? 5'(c) : 5'h1F;
      ne = (c <= 10 || c == 12 || (c >= 15 && c <= 18)) ? 5'(c) : 5'h1F;
      ctl = 16'h0008;
      @(posedge clk);
      #1;
      chk(pr, pe);
      chk(nr, ne);
      ctl = 16'h0010;
      @(posedge clk);
      #1;
      chk(nr, ne);
      ctl = 16'h0000;
      @(posedge clk);
      #1;
      chk(nr, 5'h11);
      ctl = 16'h0018;
      @(posedge clk);
      #1;
      chk(nr, 5'h1F);
    end
    $display("test routing done");
  endtask

  // one conversion; busy pin enabled or not, gpio held low to tell apart
  task automatic t_conv(input logic [11:0] lvl, input logic [11:0] exp,
                        input logic pin);
    int n;
    int k;
    level = lvl;
    gpio = 1'b0;
    ctl = pin ? 16'h00C0 : 16'h0080;
    wr(ACS_ADDR_POS, 32'h00000003);
    @(posedge clk);
    #1;
    trig = 1'b1;
    @(posedge clk);
    #1;
    trig = 1'b0;
    n = 0;
    k = 0;
    while (busy !== 1'b1 && k < 4)
    begin
      @(posedge clk);
      #1;
      k++;
    end
    while (busy === 1'b1 && n < 20)
    begin
      chk(pr, 5'h1F);
      chk(nr, 5'h1F);
      chk(ssc, 1'b0);
      if (n == 0) chk(trial, 32'h00000800);
      chk(p0, pin);
      n++;
      @(posedge clk);
      #1;
    end
    chk(n, 32'd12);
    @(posedge clk);
    #1;
    chk(irq, 1'b1);
    rc(ACS_ADDR_STA, 32'h00000001);
    rc(ACS_ADDR_DAT, {20'h00000, exp});
    chk(irq, 1'b0);
    rc(ACS_ADDR_STA, 32'h00000000);
    gpio = 1'b1;
    #1;
    chk(p0, !pin);
    $display("test conversion done");
  endtask

  // refused start, then abort by the interface reset register
  task automatic t_abort;
    wr(ACS_ADDR_OFS, 32'h00000007);
    ctl = 16'h0000;
    @(posedge clk);
    #1;
    trig = 1'b1;
    @(posedge clk);
    #1;
    trig = 1'b0;
    repeat (3) @(posedge clk);
    #1;
    chk(busy, 1'b0);
    ctl = 16'h0080;
    trig = 1'b1;
    @(posedge clk);
    #1;
    trig = 1'b0;
    repeat (3) @(posedge clk);
    #1;
    chk(busy, 1'b1);
    wr(ACS_ADDR_RST, 32'h000000A5);
    chk(busy, 1'b0);
    rc(ACS_ADDR_DAT, 32'h00000000);
    rc(ACS_ADDR_POS, 32'h00000000);
    rc(ACS_ADDR_NEG, 32'h00000001);
    rc(ACS_ADDR_GAIN, {22'h000000, GAIN_F});
    rc(ACS_ADDR_OFS, {22'h000000, OFS_F});
    rc(ACS_ADDR_STA, 32'h00000000);
    $display("test abort_reset done");
  endtask

  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // main sequence; offset 5 first, then raw result with offset 0
  initial
  begin
    failures = 0;
    cmp_count = 0;
    reset_n = 1'b0;
    bus_wr = 1'b0;
    bus_rd = 1'b0;
    trig = 1'b0;
    gpio = 1'b0;
    addr = 32'h00000000;
    wdata = 32'h00000000;
    ctl = 16'h0000;
    level = 12'h000;
    repeat (16) @(posedge clk);
    #1;
    reset_n = 1'b1;
    t_reset();
    t_regs();
    t_route();
    t_conv(12'hA5C, 12'hA61, 1'b1);
    wr(ACS_ADDR_OFS, 32'h00000000);
    t_conv(12'h3C1, 12'h3C1, 1'b0);
    t_abort();
    wrap_up();
  end

  // watchdog sized well past the expected run of roughly 440 cycles
  initial
  begin
    #200000;
    failures++;
    wrap_up();
  end
endmodule
